// >>> mcal_pkg.sv
// ==========================================================================
`default_nettype none
package mcal_pkg;
	// ======================================================================
	// Device map
	localparam logic [7:0]  TBL_SEL_ADDR   = 8'h7F;
	localparam logic [7:0]  TBL_CAL        = 8'h02;
	localparam logic [7:0]  SHIFT_A_ADDR   = 8'h8E;
	localparam logic [7:0]  SHIFT_B_ADDR   = 8'h8F;
	localparam logic [7:0]  SCALE_BASE     = 8'h94;
	localparam logic [7:0]  OFFSET_BASE    = 8'hA4;
	localparam logic [7:0]  READING_BASE   = 8'h64;
	localparam logic [7:0]  SHIFT_RESET    = 8'h00;
	localparam int          SHIFT_HI_POS   = 4;
	localparam int          SHIFT_LO_POS   = 0;
	localparam logic [15:0] CLAMP_FULL     = 16'hFFF8;
	localparam logic [15:0] OFFSET_ZERO    = 16'h0000;
	// ======================================================================
	// Software register map (APB byte addresses)
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_EXPECT     = 8'h04;
	localparam logic [7:0]  REG_STATUS     = 8'h08;
	localparam logic [7:0]  REG_READINGS   = 8'h0C;
	localparam logic [7:0]  REG_OFFSET     = 8'h10;
	localparam int          CTRL_START_POS = 0;
	localparam int          CTRL_CH_POS    = 4;
	localparam int          CTRL_SHIFT_POS = 8;
	localparam int          STAT_BUSY_POS  = 0;
	localparam int          STAT_DONE_POS  = 1;
	localparam int          STAT_SCALE_POS = 16;
	// ======================================================================
	// Timing
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          SETTLE_NS      = 100000;
	localparam int          SETTLE_CYCLES  = SETTLE_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// >>> mcal_settle.sv
`timescale 1ns/1ps
`default_nettype none
module mcal_settle #(
	parameter int CYCLES = 16
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic start,
	output logic      done
);
	logic [31:0] count;
	logic        run;

	// ======================================================================
	// Counts out one conversion period after a gain or level change
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count <= 32'h00000000;
			run   <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				count <= 32'h00000001;
				run   <= 1'b1;
			end else if (run) begin
				if (count >= 32'(CYCLES)) begin
					run  <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count + 32'h00000001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> mcal_dev_xfer.sv
`timescale 1ns/1ps
`default_nettype none
module mcal_dev_xfer (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        op_req,
	input  wire logic        op_wr,
	input  wire logic        op_word,
	input  wire logic [7:0]  op_addr,
	input  wire logic [15:0] op_wdata,
	output logic             op_done,
	output logic [15:0]      op_rdata,
	output logic             dev_req,
	output logic             dev_wr,
	output logic [7:0]       dev_addr,
	output logic [7:0]       dev_wdata,
	input  wire logic [7:0]  dev_rdata,
	input  wire logic        dev_ack
);
	logic       busy;
	logic       word;
	logic       second;
	logic       gap;
	logic [7:0] low_byte;

	// ======================================================================
	// Word transfers are two byte cycles, high byte at the lower address
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			busy      <= 1'b0;
			word      <= 1'b0;
			second    <= 1'b0;
			gap       <= 1'b0;
			low_byte  <= 8'h00;
			op_done   <= 1'b0;
			op_rdata  <= 16'h0000;
			dev_req   <= 1'b0;
			dev_wr    <= 1'b0;
			dev_addr  <= 8'h00;
			dev_wdata <= 8'h00;
		end else begin
			op_done <= 1'b0;
			if (op_req && !busy) begin
				busy      <= 1'b1;
				word      <= op_word;
				second    <= 1'b0;
				low_byte  <= op_wdata[7:0];
				op_rdata  <= 16'h0000;
				dev_req   <= 1'b1;
				dev_wr    <= op_wr;
				dev_addr  <= op_addr;
				dev_wdata <= op_word ? op_wdata[15:8] : op_wdata[7:0];
			end else if (dev_req && dev_ack) begin
				dev_req <= 1'b0;
				if (!dev_wr) begin
					if (word && !second) begin
						op_rdata[15:8] <= dev_rdata;
					end else begin
						op_rdata[7:0] <= dev_rdata;
					end
				end
				if (word && !second) begin
					second <= 1'b1;
					gap    <= 1'b1;
				end else begin
					busy    <= 1'b0;
					op_done <= 1'b1;
				end
			end else if (gap) begin
				// One idle cycle between bytes so the device sees a fresh request
				gap       <= 1'b0;
				dev_req   <= 1'b1;
				dev_addr  <= dev_addr + 8'h01;
				dev_wdata <= low_byte;
			end
		end
	end
endmodule
`default_nettype wire

// >>> mcal_ctrl.sv
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module mcal_ctrl #(
	parameter int SETTLE_CYCLES = mcal_pkg::SETTLE_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             dev_req,
	output logic             dev_wr,
	output logic [7:0]       dev_addr,
	output logic [7:0]       dev_wdata,
	input  wire logic [7:0]  dev_rdata,
	input  wire logic        dev_ack,
	output logic [1:0]       force_channel,
	output logic             force_high,
	output logic             force_null
);
	typedef enum {
		ST_IDLE, ST_SEL_TBL, ST_RD_SHIFT, ST_WR_SHIFT0, ST_WR_OFS0,
		ST_TRY, ST_HI_WAIT, ST_RD_HI, ST_NULL_WAIT, ST_RD_NULL, ST_JUDGE,
		ST_NEXT, ST_WR_SCALE, ST_FIN_WAIT, ST_FIN_RD, ST_WR_OFS, ST_WR_SHIFT,
		ST_DONE
	} mcal_state_t;

	mcal_state_t state;
	logic [1:0]  channel;
	logic [2:0]  final_shift;
	logic [15:0] expected_null_count;
	logic [15:0] expected_high_count;
	logic        start_pulse;
	logic        done_flag;
	logic [15:0] trial;
	logic [3:0]  bit_idx;
	logic [15:0] high_reading;
	logic [15:0] null_reading;
	logic [15:0] offset_value;
	logic [7:0]  shift_byte;
	logic [2:0]  cur_shift;
	logic        issued;
	logic        op_req;
	logic        op_wr;
	logic        op_word;
	logic [7:0]  op_addr;
	logic [15:0] op_wdata;
	logic        op_done;
	logic [15:0] op_rdata;
	logic        wait_start;
	logic        wait_done;
	logic [15:0] clamp;
	logic [16:0] meas_diff;
	logic [16:0] exp_diff;
	logic [7:0]  shift_addr;
	logic [7:0]  ch_word_ofs;
	logic [7:0]  shift_mask;
	logic [7:0]  final_field;

	// ======================================================================
	// Derived values
	assign clamp       = mcal_pkg::CLAMP_FULL >> cur_shift;
	assign meas_diff   = {1'b0, high_reading} - {1'b0, null_reading};
	assign exp_diff    = {1'b0, expected_high_count} - {1'b0, expected_null_count};
	assign ch_word_ofs = {5'b00000, channel, 1'b0};
	assign shift_addr  = channel[1] ? mcal_pkg::SHIFT_B_ADDR : mcal_pkg::SHIFT_A_ADDR;
	// Even channel of a pair sits in the upper field
	assign shift_mask  = channel[0] ? (8'h07 << mcal_pkg::SHIFT_LO_POS)
	                                : (8'h07 << mcal_pkg::SHIFT_HI_POS);
	assign final_field = channel[0] ? ({5'b00000, final_shift} << mcal_pkg::SHIFT_LO_POS)
	                                : ({5'b00000, final_shift} << mcal_pkg::SHIFT_HI_POS);

	// ======================================================================
	// APB slave, zero wait states
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel && !penable && !pready;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
			if (psel && !penable) begin
				if (paddr == mcal_pkg::REG_CTRL) begin
					prdata <= {21'h000000, final_shift, 2'b00, channel, 4'h0};
				end else if (paddr == mcal_pkg::REG_EXPECT) begin
					prdata <= {expected_high_count, expected_null_count};
				end else if (paddr == mcal_pkg::REG_STATUS) begin
					// A finished run is not busy: it takes a new start at once
					prdata <= {trial, 14'h0000, done_flag, state != ST_IDLE && state != ST_DONE};
				end else if (paddr == mcal_pkg::REG_READINGS) begin
					prdata <= {high_reading, null_reading};
				end else if (paddr == mcal_pkg::REG_OFFSET) begin
					prdata <= {16'h0000, offset_value};
				end else begin
					pslverr <= 1'b1;
				end
			end
		end
	end

	// Setup written at the access edge; start is ignored while busy
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			channel             <= 2'b00;
			final_shift         <= 3'b000;
			expected_null_count <= 16'h0000;
			expected_high_count <= 16'h0000;
			start_pulse         <= 1'b0;
		end else begin
			start_pulse <= 1'b0;
			if (psel && penable && pready && pwrite) begin
				if (paddr == mcal_pkg::REG_CTRL) begin
					if (state == ST_IDLE || state == ST_DONE) begin
						channel     <= pwdata[mcal_pkg::CTRL_CH_POS +: 2];
						final_shift <= pwdata[mcal_pkg::CTRL_SHIFT_POS +: 3];
						start_pulse <= pwdata[mcal_pkg::CTRL_START_POS];
					end
				end else if (paddr == mcal_pkg::REG_EXPECT) begin
					// Counts already scaled by the applied input fraction
					expected_null_count <= pwdata[15:0];
					expected_high_count <= pwdata[31:16];
				end
			end
		end
	end

	// ======================================================================
	// Device access and settling helpers
	mcal_dev_xfer u_xfer (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.op_req    (op_req),
		.op_wr     (op_wr),
		.op_word   (op_word),
		.op_addr   (op_addr),
		.op_wdata  (op_wdata),
		.op_done   (op_done),
		.op_rdata  (op_rdata),
		.dev_req   (dev_req),
		.dev_wr    (dev_wr),
		.dev_addr  (dev_addr),
		.dev_wdata (dev_wdata),
		.dev_rdata (dev_rdata),
		.dev_ack   (dev_ack)
	);

	mcal_settle #(
		.CYCLES (SETTLE_CYCLES)
	) u_settle (
		.sys_clk (sys_clk),
		.rst     (rst),
		.start   (wait_start),
		.done    (wait_done)
	);

	// ======================================================================
	// Calibration sequence; each step that touches the device issues one operation and waits for it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state         <= ST_IDLE;
			issued        <= 1'b0;
			op_req        <= 1'b0;
			op_wr         <= 1'b0;
			op_word       <= 1'b0;
			op_addr       <= 8'h00;
			op_wdata      <= 16'h0000;
			wait_start    <= 1'b0;
			trial         <= 16'h0000;
			bit_idx       <= 4'hF;
			high_reading  <= 16'h0000;
			null_reading  <= 16'h0000;
			offset_value  <= 16'h0000;
			shift_byte    <= mcal_pkg::SHIFT_RESET;
			cur_shift     <= 3'b000;
			done_flag     <= 1'b0;
			force_channel <= 2'b00;
			force_high    <= 1'b0;
			force_null    <= 1'b0;
		end else begin
			op_req     <= 1'b0;
			wait_start <= 1'b0;
			case (state)
			ST_IDLE, ST_DONE: begin
				if (start_pulse) begin
					done_flag     <= 1'b0;
					force_channel <= channel;
					trial         <= 16'h0000;
					bit_idx       <= 4'hF;
					state         <= ST_SEL_TBL;
				end
			end
			ST_SEL_TBL: begin
				if (!issued) begin
					issued   <= 1'b1;
					op_req   <= 1'b1;
					op_wr    <= 1'b1;
					op_word  <= 1'b0;
					op_addr  <= mcal_pkg::TBL_SEL_ADDR;
					op_wdata <= {8'h00, mcal_pkg::TBL_CAL};
				end else if (op_done) begin
					issued <= 1'b0;
					state  <= ST_RD_SHIFT;
				end
			end
			ST_RD_SHIFT: begin
				if (!issued) begin
					issued  <= 1'b1;
					op_req  <= 1'b1;
					op_wr   <= 1'b0;
					op_word <= 1'b0;
					op_addr <= shift_addr;
				end else if (op_done) begin
					issued     <= 1'b0;
					shift_byte <= op_rdata[7:0];
					state      <= ST_WR_SHIFT0;
				end
			end
			ST_WR_SHIFT0: begin
				if (!issued) begin
					// Keep the partner channel's count untouched
					issued   <= 1'b1;
					op_req   <= 1'b1;
					op_wr    <= 1'b1;
					op_addr  <= shift_addr;
					op_wdata <= {8'h00, shift_byte & ~shift_mask};
				end else if (op_done) begin
					issued    <= 1'b0;
					cur_shift <= 3'b000;
					state     <= ST_WR_OFS0;
				end
			end
			ST_WR_OFS0: begin
				if (!issued) begin
					issued   <= 1'b1;
					op_req   <= 1'b1;
					op_wr    <= 1'b1;
					op_word  <= 1'b1;
					op_addr  <= mcal_pkg::OFFSET_BASE + ch_word_ofs;
					op_wdata <= mcal_pkg::OFFSET_ZERO;
				end else if (op_done) begin
					issued <= 1'b0;
					state  <= ST_TRY;
				end
			end
			ST_TRY: begin
				if (!issued) begin
					issued   <= 1'b1;
					trial    <= trial | (16'h0001 << bit_idx);
					op_req   <= 1'b1;
					op_wr    <= 1'b1;
					op_word  <= 1'b1;
					op_addr  <= mcal_pkg::SCALE_BASE + ch_word_ofs;
					op_wdata <= trial | (16'h0001 << bit_idx);
				end else if (op_done) begin
					issued     <= 1'b0;
					force_high <= 1'b1;
					force_null <= 1'b0;
					wait_start <= 1'b1;
					state      <= ST_HI_WAIT;
				end
			end
			ST_HI_WAIT, ST_NULL_WAIT, ST_FIN_WAIT: begin
				if (wait_done) begin
					if (state == ST_HI_WAIT) begin
						state <= ST_RD_HI;
					end else if (state == ST_NULL_WAIT) begin
						state <= ST_RD_NULL;
					end else begin
						state <= ST_FIN_RD;
					end
				end
			end
			ST_RD_HI, ST_RD_NULL, ST_FIN_RD: begin
				if (!issued) begin
					issued  <= 1'b1;
					op_req  <= 1'b1;
					op_wr   <= 1'b0;
					op_word <= 1'b1;
					op_addr <= mcal_pkg::READING_BASE + ch_word_ofs;
				end else if (op_done) begin
					issued <= 1'b0;
					if (state == ST_RD_HI) begin
						high_reading <= op_rdata;
						if (op_rdata >= clamp) begin
							trial <= trial & ~(16'h0001 << bit_idx);
							state <= ST_NEXT;
						end else begin
							force_high <= 1'b0;
							force_null <= 1'b1;
							wait_start <= 1'b1;
							state      <= ST_NULL_WAIT;
						end
					end else if (state == ST_RD_NULL) begin
						null_reading <= op_rdata;
						state        <= ST_JUDGE;
					end else begin
						null_reading <= op_rdata;
						// Null must read zero: correction is the reading shifted right by two
						offset_value <= {2'b00, op_rdata[15:2]};
						force_null   <= 1'b0;
						state        <= ST_WR_OFS;
					end
				end
			end
			ST_JUDGE: begin
				// Unsigned-safe: both differences widened by one bit
				if ($signed(meas_diff) > $signed(exp_diff)) begin
					trial <= trial & ~(16'h0001 << bit_idx);
				end
				state <= ST_NEXT;
			end
			ST_NEXT: begin
				force_high <= 1'b0;
				force_null <= 1'b0;
				if (bit_idx == 4'h0) begin
					state <= ST_WR_SCALE;
				end else begin
					bit_idx <= bit_idx - 4'h1;
					state   <= ST_TRY;
				end
			end
			ST_WR_SCALE: begin
				if (!issued) begin
					issued   <= 1'b1;
					op_req   <= 1'b1;
					op_wr    <= 1'b1;
					op_word  <= 1'b1;
					op_addr  <= mcal_pkg::SCALE_BASE + ch_word_ofs;
					op_wdata <= trial;
				end else if (op_done) begin
					issued     <= 1'b0;
					force_null <= 1'b1;
					wait_start <= 1'b1;
					state      <= ST_FIN_WAIT;
				end
			end
			ST_WR_OFS: begin
				if (!issued) begin
					issued   <= 1'b1;
					op_req   <= 1'b1;
					op_wr    <= 1'b1;
					op_word  <= 1'b1;
					op_addr  <= mcal_pkg::OFFSET_BASE + ch_word_ofs;
					op_wdata <= offset_value;
				end else if (op_done) begin
					issued <= 1'b0;
					state  <= ST_WR_SHIFT;
				end
			end
			ST_WR_SHIFT: begin
				if (!issued) begin
					// Shifting goes on last, after gain and offset are trimmed
					issued   <= 1'b1;
					op_req   <= 1'b1;
					op_wr    <= 1'b1;
					op_word  <= 1'b0;
					op_addr  <= shift_addr;
					op_wdata <= {8'h00, (shift_byte & ~shift_mask) | final_field};
				end else if (op_done) begin
					issued    <= 1'b0;
					cur_shift <= final_shift;
					done_flag <= 1'b1;
					state     <= ST_DONE;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> mcal_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Port checker for the calibration controller
module mcal_ctrl_assertions #(
	parameter int SETTLE_CYCLES = 4
) (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        dev_req,
	input wire logic        dev_wr,
	input wire logic [7:0]  dev_addr,
	input wire logic [7:0]  dev_wdata,
	input wire logic        dev_ack,
	input wire logic        force_high,
	input wire logic        force_null
);
	// ======================================================================
	// Cycles since a forced level last changed
	logic        fh_d;
	logic        fn_d;
	logic [15:0] since;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fh_d  <= 1'h0;
			fn_d  <= 1'h0;
			since <= 16'h0000;
		end else begin
			fh_d <= force_high;
			fn_d <= force_null;
			if (force_high != fh_d || force_null != fn_d) begin
				since <= 16'h0001;
			end else if (since != 16'hFFFF) begin
				since <= since + 16'h0001;
			end
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence seq_accept;
		dev_req && dev_ack;
	endsequence
	sequence seq_pending;
		dev_req && !dev_ack;
	endsequence
	a_dev_release: assert property (seq_accept |=> !dev_req)
		else $error("device request not released");
	a_dev_hold: assert property (seq_pending |=> dev_req && $stable(dev_addr)
		&& $stable(dev_wr) && $stable(dev_wdata)) else $error("device request moved");
	a_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
	a_pready_once: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h00000000)
		else $error("error without ready or with data");
	a_force_excl: assert property (!(force_high && force_null))
		else $error("both levels forced");
	a_table_sel: assert property (dev_req && dev_wr && dev_addr == 8'h7F
		|-> dev_wdata == 8'h02) else $error("wrong table selected");
	a_shift_loose: assert property (dev_req && dev_wr && dev_addr[7:1] == 7'h47
		|-> !dev_wdata[7] && !dev_wdata[3]) else $error("unused shift bits set");
	a_settle_wait: assert property (dev_req && !dev_wr && (force_high || force_null)
		|-> since >= 16'(SETTLE_CYCLES - 1)) else $error("reading taken before settling");
endmodule
bind mcal_ctrl mcal_ctrl_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES))
	mcal_ctrl_assertions_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .dev_req(dev_req), .dev_wr(dev_wr),
	.dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_ack(dev_ack),
	.force_high(force_high), .force_null(force_null));
`default_nettype wire

// >>> mcal_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Converter device: table select, calibration bytes, readings
module mcal_dev_model (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        dev_req,
	input  wire logic        dev_wr,
	input  wire logic [7:0]  dev_addr,
	input  wire logic [7:0]  dev_wdata,
	output logic [7:0]       dev_rdata,
	output logic             dev_ack,
	input  wire logic [1:0]  force_channel,
	input  wire logic        force_high,
	input  wire logic        force_null,
	input  wire logic [15:0] v_hi,
	input  wire logic [15:0] v_null
);
	logic [7:0] mem [0:255];
	logic [1:0] stall;
	// Gain law, 13-bit left justified, clamped at full scale
	function automatic logic [15:0] conv(input logic [15:0] v, input logic [15:0] s);
		logic [31:0] x;
		x = (32'(v) * 32'(s)) >> 14;
		return (x > 32'h0000FFF8) ? 16'hFFF8 : (x[15:0] & 16'hFFF8);
	endfunction
	// Offset not applied: it stays zero until after the last reading
	function automatic logic [7:0] rd_byte(input logic [7:0] a);
		logic [1:0]  ch;
		logic [7:0]  sb;
		logic [2:0]  sh;
		logic [15:0] lv;
		logic [15:0] val;
		ch  = 2'((a - 8'h64) >> 1);
		sb  = mem[8'h8E + 8'(ch[1])];
		sh  = ch[0] ? sb[2:0] : sb[6:4];
		lv  = (force_channel != ch) ? 16'h0000 : force_high ? v_hi : force_null ? v_null : 16'h0000;
		val = conv(lv, {mem[8'h94 + 8'(2 * ch)], mem[8'h95 + 8'(2 * ch)]}) >> sh;
		if (a >= 8'h64 && a <= 8'h6B) return a[0] ? val[7:0] : val[15:8];
		return (a >= 8'h80 && mem[8'h7F] != 8'h02) ? ~dev_rdata : mem[a];
	endfunction
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 256; i++) begin
				mem[i] <= 8'h00;
			end
			dev_ack   <= 1'h0;
			dev_rdata <= 8'h00;
			stall     <= 2'h0;
		end else begin
			dev_ack   <= 1'h0;
			dev_rdata <= ~dev_rdata;
			if (dev_req && dev_ack) begin
				if (dev_wr && (dev_addr < 8'h80 || mem[8'h7F] == 8'h02)) begin
					mem[dev_addr] <= dev_wdata;
				end
				stall <= 2'($urandom_range(3));
			end else if (dev_req && stall != 2'h0) begin
				stall <= stall - 2'h1;
			end else if (dev_req) begin
				dev_ack   <= 1'h1;
				dev_rdata <= rd_byte(dev_addr);
			end
		end
	end
endmodule
`default_nettype wire

// >>> mcal_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mcal_ctrl_tb_top;
	localparam int SETTLE = 4;
	typedef struct {logic [31:0] data; logic [31:0] mask; logic err;} mcal_exp_t;
	logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
	logic        dev_req, dev_wr, dev_ack, force_high, force_null;
	logic [1:0]  force_channel;
	logic [7:0]  paddr, dev_addr, dev_wdata, dev_rdata;
	logic [15:0] v_hi, v_null;
	logic [31:0] pwdata, prdata, rd_val;
	logic [2:0]  sh_set [0:3];
	mcal_exp_t   exp_q [$];
	int          num_errors = 0, compares = 0, cycles = 0;
	mcal_ctrl #(.SETTLE_CYCLES(SETTLE)) mcal_ctrl_inst (
		.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dev_req(dev_req), .dev_wr(dev_wr), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
		.dev_rdata(dev_rdata), .dev_ack(dev_ack), .force_channel(force_channel),
		.force_high(force_high), .force_null(force_null));
	mcal_dev_model mcal_dev_model_inst (
		.sys_clk(sys_clk), .rst(rst), .dev_req(dev_req), .dev_wr(dev_wr),
		.dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .dev_ack(dev_ack),
		.force_channel(force_channel), .force_high(force_high), .force_null(force_null),
		.v_hi(v_hi), .v_null(v_null));
	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end
	// ======================================================================
	// Checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			test_done();
		end
	end
	// Each answered transfer retires the oldest note
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'h1) begin
			if (exp_q.size() == 0) begin
				num_errors++;
				$display("BAD %0t answer with no expectation", $time);
			end else begin
				check(32'(pslverr), 32'(exp_q[0].err));
				check(prdata & exp_q[0].mask, exp_q[0].data & exp_q[0].mask);
				void'(exp_q.pop_front());
			end
		end
	end
	// ======================================================================
	// Bus tasks
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] m, input logic [31:0] e, input logic err);
		exp_q.push_back('{e, m, err});
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		// No cycle count assumed: only the bench timeout ends this wait
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'h1);
		rd_val = prdata;
		psel    <= 1'h0;
		penable <= 1'h0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d, 32'h0, 32'h0, 1'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'h0, a, 32'h0, m, e, 1'h0);
	endtask
	// ======================================================================
	// One calibration run, expected result from the binary search itself
	task automatic calibrate(input logic [1:0] ch, input logic [2:0] sh);
		logic [15:0] en, eh, hv, nv, s, t, h, nl;
		logic [7:0]  pair;
		int          n;
		en = 16'($urandom_range(16'h3000));
		eh = en + 16'($urandom_range(16'hA000, 16'h2000));
		hv = 16'($urandom_range(16'hFFFF, 16'h8000));
		nv = 16'($urandom_range(16'h2000));
		v_hi   <= hv;
		v_null <= nv;
		s = 16'h0000;
		for (int b = 15; b >= 0; b--) begin
			t  = s | 16'(1 << b);
			h  = mcal_dev_model_inst.conv(hv, t);
			nl = mcal_dev_model_inst.conv(nv, t);
			if (h < 16'hFFF8 && $signed({1'h0, h} - {1'h0, nl})
					<= $signed({1'h0, eh} - {1'h0, en})) begin
				s = t;
			end
		end
		sh_set[ch] = sh;
		pair = {1'h0, sh_set[{ch[1], 1'h0}], 1'h0, sh_set[{ch[1], 1'h1}]};
		wr(mcal_pkg::REG_EXPECT, {eh, en});
		rd(mcal_pkg::REG_EXPECT, 32'hFFFFFFFF, {eh, en});
		wr(mcal_pkg::REG_CTRL, {21'h0, sh, 2'h0, ch, 4'h1});
		wr(mcal_pkg::REG_CTRL, {21'h0, ~sh, 2'h0, ~ch, 4'h1});
		n = 0;
		do begin
			rd(mcal_pkg::REG_STATUS, 32'h0, 32'h0);
			n++;
		end while (rd_val[mcal_pkg::STAT_DONE_POS] !== 1'h1 && n < 3000);
		rd(mcal_pkg::REG_STATUS, 32'hFFFF0003, {s, 16'h0002});
		rd(mcal_pkg::REG_OFFSET, 32'h0000FFFF, {16'h0, mcal_dev_model_inst.conv(nv, s) >> 2});
		rd(mcal_pkg::REG_READINGS, 32'h0000FFFF, {16'h0, mcal_dev_model_inst.conv(nv, s)});
		rd(mcal_pkg::REG_CTRL, 32'hFFFFFFFF, {21'h0, sh, 2'h0, ch, 4'h0});
		check(32'({mcal_dev_model_inst.mem[8'h94 + 8'(2 * ch)],
			mcal_dev_model_inst.mem[8'h95 + 8'(2 * ch)]}), 32'(s));
		check(32'({mcal_dev_model_inst.mem[8'hA4 + 8'(2 * ch)],
			mcal_dev_model_inst.mem[8'hA5 + 8'(2 * ch)]}),
			32'(mcal_dev_model_inst.conv(nv, s) >> 2));
		check(32'(mcal_dev_model_inst.mem[8'h7F]), 32'h02);
		check(32'(mcal_dev_model_inst.mem[8'h8E + 8'(ch[1])]), 32'(pair));
	endtask
	// ======================================================================
	// Main sequence
	initial begin
		rst     = 1'h1;
		psel    = 1'h0;
		penable = 1'h0;
		pwrite  = 1'h0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		v_hi    = 16'h0;
		v_null  = 16'h0;
		sh_set  = '{default: 3'h0};
		void'($urandom(74578));
		repeat (10) @(posedge sys_clk);
		rst <= 1'h0;
		@(posedge sys_clk);
		check(32'(mcal_dev_model_inst.mem[8'h8E]), 32'h00);
		check(32'(mcal_dev_model_inst.mem[8'h8F]), 32'h00);
		rd(mcal_pkg::REG_CTRL, 32'hFFFFFFFF, 32'h0);
		rd(mcal_pkg::REG_STATUS, 32'hFFFFFFFF, 32'h0);
		apb(1'h0, 8'h14, 32'h0, 32'hFFFFFFFF, 32'h0, 1'h1);
		apb(1'h1, 8'hFC, 32'hA5A5A5A5, 32'h0, 32'h0, 1'h1);
		for (int c = 0; c < 4; c++) begin
			calibrate(2'(c), (c == 3) ? 3'h7 : 3'($urandom_range(6)));
		end
		// Rerun with a stale scale and shift left behind
		calibrate(2'h0, 3'h0);
		test_done();
	end
endmodule
`default_nettype wire
